// file: hdl/aecr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module aecr_regs (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// serial control
	input  wire logic        frame_active,
	input  wire logic        bit_valid,
	input  wire logic        bit_data,
	// mode and data path
	input  wire logic        extended_mode,
	input  wire logic [7:0]  adc_i,
	input  wire logic [7:0]  adc_q,
	input  wire logic [7:0]  adc_id,
	input  wire logic [7:0]  adc_qd,
	input  wire logic        adc_or,
	// analog controls
	output logic [8:0]       i_gain_code,
	output logic [8:0]       q_gain_code,
	output logic [7:0]       q_offset_mag,
	output logic             q_offset_neg,
	output logic [7:0]       phase_fine,
	output logic             sample_clock_invert,
	output logic [4:0]       phase_coarse,
	output logic [2:0]       phase_mid,
	output logic             termination_trim_disable,
	output logic             interleave_enable,
	output logic             interleave_input_select,
	output logic             low_clock_rate_mode,
	output logic             test_pattern_enable,
	output logic             cal_start,
	// data outputs
	output logic [7:0]       dout_i,
	output logic [7:0]       dout_q,
	output logic [7:0]       dout_id,
	output logic [7:0]       dout_qd,
	output logic             dout_or
);
	logic [3:0]  w_addr;
	logic [15:0] w_data;
	logic        w_valid;
	logic [15:0] i_gain_ff;
	logic [15:0] q_gain_ff;
	logic [15:0] ext_cfg_ff;
	logic [15:0] q_ofs_ff;
	logic [15:0] fine_ff;
	logic [15:0] crs_ff;
	logic [7:0]  tp_i;
	logic [7:0]  tp_q;
	logic [7:0]  tp_id;
	logic [7:0]  tp_qd;
	logic        tp_or;
	logic        tp_on;

	aecr_serial_rx u_rx (
		.clk          (clk),
		.nrst         (nrst),
		.frame_active (frame_active),
		.bit_valid    (bit_valid),
		.bit_data     (bit_data),
		.word_addr    (w_addr),
		.word_data    (w_data),
		.word_valid   (w_valid)
	);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = w_valid && a == r;
	endfunction : hit

	// full word only; reserved addresses fall through
	always_ff @(posedge clk) begin
		if (!nrst) begin
			i_gain_ff <= aecr_pkg::RST_GAIN;
		end else if (hit(w_addr, aecr_pkg::ADDR_I_GAIN)) begin
			i_gain_ff <= w_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q_gain_ff <= aecr_pkg::RST_GAIN;
		end else if (hit(w_addr, aecr_pkg::ADDR_Q_GAIN)) begin
			q_gain_ff <= w_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ext_cfg_ff <= aecr_pkg::RST_EXT_CFG;
		end else if (hit(w_addr, aecr_pkg::ADDR_EXT_CFG)) begin
			ext_cfg_ff <= w_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q_ofs_ff <= aecr_pkg::RST_Q_OFFSET;
		end else if (hit(w_addr, aecr_pkg::ADDR_Q_OFFSET)) begin
			q_ofs_ff <= w_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fine_ff <= aecr_pkg::RST_PHASE_FINE;
		end else if (hit(w_addr, aecr_pkg::ADDR_PHASE_FINE)) begin
			fine_ff <= w_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			crs_ff <= aecr_pkg::RST_PHASE_CRS;
		end else if (hit(w_addr, aecr_pkg::ADDR_PHASE_CRS)) begin
			crs_ff <= w_data;
		end
	end

	// normal mode falls back to power-on fields
	// stored words survive, so re-entering extended mode needs no rewrite
	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			i_gain_code <= aecr_pkg::RST_GAIN[aecr_pkg::GAIN_HI:aecr_pkg::GAIN_LO];
		end else begin
			i_gain_code <= i_gain_ff[aecr_pkg::GAIN_HI:aecr_pkg::GAIN_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			q_gain_code <= aecr_pkg::RST_GAIN[aecr_pkg::GAIN_HI:aecr_pkg::GAIN_LO];
		end else begin
			q_gain_code <= q_gain_ff[aecr_pkg::GAIN_HI:aecr_pkg::GAIN_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			q_offset_mag <= 8'h00;
		end else begin
			q_offset_mag <= q_ofs_ff[aecr_pkg::OFS_HI:aecr_pkg::OFS_LO];
		end
	end

	// sign kept apart from magnitude: zero magnitude must not mask it
	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			q_offset_neg <= 1'b0;
		end else begin
			q_offset_neg <= q_ofs_ff[aecr_pkg::SIGN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			phase_fine <= 8'h00;
		end else begin
			phase_fine <= fine_ff[aecr_pkg::FINE_HI:aecr_pkg::FINE_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			sample_clock_invert <= 1'b0;
		end else begin
			sample_clock_invert <= crs_ff[aecr_pkg::POL_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			phase_coarse <= 5'h00;
		end else begin
			phase_coarse <= crs_ff[aecr_pkg::CRS_HI:aecr_pkg::CRS_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			phase_mid <= 3'h0;
		end else begin
			phase_mid <= crs_ff[aecr_pkg::MID_HI:aecr_pkg::MID_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			termination_trim_disable <= 1'b0;
		end else begin
			termination_trim_disable <= ext_cfg_ff[aecr_pkg::RTD_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			interleave_enable <= 1'b0;
		end else begin
			interleave_enable <= ext_cfg_ff[aecr_pkg::DES_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			interleave_input_select <= 1'b0;
		end else begin
			interleave_input_select <= ext_cfg_ff[aecr_pkg::ISEL_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			low_clock_rate_mode <= 1'b0;
		end else begin
			low_clock_rate_mode <= ext_cfg_ff[aecr_pkg::DLF_BIT];
		end
	end

	// flag flips on the same edge as the first pattern word on dout
	always_ff @(posedge clk) begin
		if (!nrst || !extended_mode) begin
			test_pattern_enable <= 1'b0;
		end else begin
			test_pattern_enable <= ext_cfg_ff[aecr_pkg::TPO_BIT];
		end
	end

	// no path from gain writes to calibration
	always_ff @(posedge clk) begin
		cal_start <= 1'b0;
	end

	assign tp_on = extended_mode && ext_cfg_ff[aecr_pkg::TPO_BIT];

	aecr_test_pattern u_tp (
		.clk    (clk),
		.nrst   (nrst),
		.enable (tp_on),
		.tp_i   (tp_i),
		.tp_q   (tp_q),
		.tp_id  (tp_id),
		.tp_qd  (tp_qd),
		.tp_or  (tp_or)
	);

	// converter data disconnected in pattern mode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dout_i  <= 8'h00;
			dout_q  <= 8'h00;
			dout_id <= 8'h00;
			dout_qd <= 8'h00;
			dout_or <= 1'b0;
		end else if (tp_on) begin
			dout_i  <= tp_i;
			dout_q  <= tp_q;
			dout_id <= tp_id;
			dout_qd <= tp_qd;
			dout_or <= tp_or;
		end else begin
			dout_i  <= adc_i;
			dout_q  <= adc_q;
			dout_id <= adc_id;
			dout_qd <= adc_qd;
			dout_or <= adc_or;
		end
	end
endmodule : aecr_regs
`default_nettype wire

// file: hdl/aecr_pkg.sv
package aecr_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// register addresses
	localparam logic [3:0] ADDR_I_GAIN     = 4'h3;
	localparam logic [3:0] ADDR_EXT_CFG    = 4'h9;
	localparam logic [3:0] ADDR_Q_OFFSET   = 4'hA;
	localparam logic [3:0] ADDR_Q_GAIN     = 4'hB;
	localparam logic [3:0] ADDR_PHASE_FINE = 4'hE;
	localparam logic [3:0] ADDR_PHASE_CRS  = 4'hF;
	// power-on values
	localparam logic [15:0] RST_GAIN       = 16'h807F;
	localparam logic [15:0] RST_EXT_CFG    = 16'h03FF;
	localparam logic [15:0] RST_Q_OFFSET   = 16'h007F;
	localparam logic [15:0] RST_PHASE_FINE = 16'h00FF;
	localparam logic [15:0] RST_PHASE_CRS  = 16'h007F;
	// field positions
	localparam int GAIN_HI   = 15;
	localparam int GAIN_LO   = 7;
	localparam int TPO_BIT   = 15;
	localparam int RTD_BIT   = 14;
	localparam int DES_BIT   = 13;
	localparam int ISEL_BIT  = 12;
	localparam int DLF_BIT   = 10;
	localparam int OFS_HI    = 15;
	localparam int OFS_LO    = 8;
	localparam int SIGN_BIT  = 7;
	localparam int FINE_HI   = 15;
	localparam int FINE_LO   = 8;
	localparam int POL_BIT   = 15;
	localparam int CRS_HI    = 14;
	localparam int CRS_LO    = 10;
	localparam int MID_HI    = 9;
	localparam int MID_LO    = 7;
	localparam logic [4:0] BIT_CNT_LAST = 5'h13;
	localparam logic [7:0] TP_I   = 8'h04;
	localparam logic [7:0] TP_Q   = 8'h03;
	localparam logic [7:0] TP_ID  = 8'h02;
	localparam logic [7:0] TP_QD  = 8'h01;
endpackage : aecr_pkg

// file: hdl/aecr_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
// shifts in address (msb first) then 16 data bits; pulses on the 20th bit
module aecr_serial_rx (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// serial side
	input  wire logic        frame_active,
	input  wire logic        bit_valid,
	input  wire logic        bit_data,
	// word out
	output logic [3:0]       word_addr,
	output logic [15:0]      word_data,
	output logic             word_valid
);
	logic [4:0]  cnt_ff;
	logic [19:0] shift_ff;
	logic        valid_ff;

	always_ff @(posedge clk) begin
		if (!nrst || !frame_active) begin
			cnt_ff <= 5'h00;
		end else if (bit_valid && cnt_ff != aecr_pkg::BIT_CNT_LAST) begin
			cnt_ff <= cnt_ff + 5'h01;
		end else if (bit_valid) begin
			cnt_ff <= 5'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			shift_ff <= 20'h00000;
		end else if (frame_active && bit_valid) begin
			shift_ff <= {shift_ff[18:0], bit_data};
		end
	end

	// a short frame never pulses, so partial words are dropped
	always_ff @(posedge clk) begin
		if (!nrst) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= frame_active && bit_valid &&
				cnt_ff == aecr_pkg::BIT_CNT_LAST;
		end
	end

	assign word_addr  = shift_ff[19:16];
	assign word_data  = shift_ff[15:0];
	assign word_valid = valid_ff;
endmodule : aecr_serial_rx
`default_nettype wire

// file: hdl/aecr_test_pattern.sv
`timescale 1ns/1ps
`default_nettype none
// alternates each word with its complement, out-of-range follows
module aecr_test_pattern (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        enable,
	output logic [7:0]       tp_i,
	output logic [7:0]       tp_q,
	output logic [7:0]       tp_id,
	output logic [7:0]       tp_qd,
	output logic             tp_or
);
	logic phase_ff;

	always_ff @(posedge clk) begin
		if (!nrst || !enable) begin
			phase_ff <= 1'b0;
		end else begin
			phase_ff <= ~phase_ff;
		end
	end

	assign tp_i  = phase_ff ? ~aecr_pkg::TP_I  : aecr_pkg::TP_I;
	assign tp_q  = phase_ff ? ~aecr_pkg::TP_Q  : aecr_pkg::TP_Q;
	assign tp_id = phase_ff ? ~aecr_pkg::TP_ID : aecr_pkg::TP_ID;
	assign tp_qd = phase_ff ? ~aecr_pkg::TP_QD : aecr_pkg::TP_QD;
	assign tp_or = phase_ff;
endmodule : aecr_test_pattern
`default_nettype wire

// file: testbench/aecr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aecr_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// inputs watched
	input wire logic       frame_active,
	input wire logic       extended_mode,
	input wire logic [7:0] adc_i,
	// controls
	input wire logic [8:0] i_gain_code,
	input wire logic [8:0] q_gain_code,
	input wire logic [7:0] q_offset_mag,
	input wire logic       q_offset_neg,
	input wire logic [7:0] phase_fine,
	input wire logic       sample_clock_invert,
	input wire logic [4:0] phase_coarse,
	input wire logic [2:0] phase_mid,
	input wire logic       test_pattern_enable,
	input wire logic       cal_start,
	// data
	input wire logic [7:0] dout_i,
	input wire logic [7:0] dout_q,
	input wire logic [7:0] dout_id,
	input wire logic [7:0] dout_qd,
	input wire logic       dout_or
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence tp_on;
		test_pattern_enable [*4];
	endsequence
	sequence quiet;
		(!frame_active && extended_mode) [*4];
	endsequence
	cal_idle_a: assert property (!cal_start)
		else $error("calibration started");
	gain_reset_a: assert property ($rose(nrst) |->
		i_gain_code == 9'h100 && q_gain_code == 9'h100) else $error("gain reset");
	ctrl_reset_a: assert property ($rose(nrst) |->
		{q_offset_mag, q_offset_neg, phase_fine, sample_clock_invert,
		phase_coarse, phase_mid, test_pattern_enable} == 27'h0)
		else $error("control reset");
	normal_mode_a: assert property ((!extended_mode) [*3] |->
		i_gain_code == 9'h100 && phase_fine == 8'h00 && !test_pattern_enable)
		else $error("normal mode leak");
	word_hold_a: assert property (quiet |->
		$stable({i_gain_code, q_gain_code, q_offset_mag, phase_fine}))
		else $error("control changed without a word");
	tp_toggle_a: assert property (tp_on ##0 $past(dout_i) == 8'h04 |->
		dout_i == 8'hFB) else $error("pattern does not alternate");
	tp_ports_a: assert property (tp_on |-> {dout_i, dout_q, dout_id,
		dout_qd} == (dout_or ? 32'hFBFCFDFE : 32'h04030201))
		else $error("pattern word wrong");
	data_pass_a: assert property ((!test_pattern_enable) [*3] |->
		dout_i == $past(adc_i)) else $error("data not passed");
endmodule : aecr_chk
`default_nettype wire

// file: testbench/aecr_host.sv
`timescale 1ns/1ps
`default_nettype none
module aecr_host (
	input  wire logic clk,
	output logic      frame_active,
	output logic      bit_valid,
	output logic      bit_data
);
	initial begin
		frame_active = 1'b0;
		bit_valid = 1'b0;
		bit_data = 1'b0;
	end
	function automatic logic [15:0] fix(input logic [3:0] a,
		input logic [15:0] d);
		case (a)
			4'h9: fix = d & 16'hF7FF | 16'h03FF;
			4'hE: fix = d | 16'h00FF;
			default: fix = d | 16'h007F;
		endcase
	endfunction : fix
	// address then data, msb first; idle line toggles
	task automatic send(input logic [3:0] a, input logic [15:0] d,
		input int gap, input int nbits);
		logic [19:0] w;
		w = {a, fix(a, d)};
		for (int i = 19; i > 19 - nbits; i--) begin
			@(posedge clk);
			#1;
			frame_active = 1'b1;
			bit_valid = 1'b1;
			bit_data = w[i];
			repeat (gap) begin
				@(posedge clk);
				#1;
				bit_valid = 1'b0;
				bit_data = ~bit_data;
			end
		end
	endtask : send
	task automatic end_frame;
		@(posedge clk);
		#1;
		frame_active = 1'b0;
		bit_valid = 1'b0;
		bit_data = ~bit_data;
	endtask : end_frame
endmodule : aecr_host
`default_nettype wire

// file: testbench/aecr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aecr_regs_tb;
	logic        clk, nrst, extended_mode, adc_or, frame_active, bit_valid;
	logic        bit_data, q_offset_neg, sample_clock_invert, cal_start;
	logic        termination_trim_disable, interleave_enable, dout_or;
	logic        interleave_input_select, low_clock_rate_mode;
	logic        test_pattern_enable, ph;
	logic [7:0]  adc_i, adc_q, adc_id, adc_qd, lfsr, q_offset_mag;
	logic [7:0]  phase_fine, dout_i, dout_q, dout_id, dout_qd;
	logic [8:0]  i_gain_code, q_gain_code;
	logic [4:0]  phase_coarse;
	logic [2:0]  phase_mid;
	logic [15:0] rg [16];
	logic [15:0] d;
	logic [32:0] pv;
	int          failures, num_checks, cyc;
	wire logic [48:0] ctl = {i_gain_code, q_gain_code, q_offset_mag,
		q_offset_neg, phase_fine, sample_clock_invert, phase_coarse,
		phase_mid, test_pattern_enable, termination_trim_disable,
		interleave_enable, interleave_input_select, low_clock_rate_mode};
	wire logic [32:0] dv = {dout_or, dout_i, dout_q, dout_id, dout_qd};
	aecr_regs dut (.clk, .nrst, .frame_active, .bit_valid, .bit_data,
		.extended_mode, .adc_i, .adc_q, .adc_id, .adc_qd, .adc_or,
		.i_gain_code, .q_gain_code, .q_offset_mag, .q_offset_neg,
		.phase_fine, .sample_clock_invert, .phase_coarse, .phase_mid,
		.termination_trim_disable, .interleave_enable,
		.interleave_input_select, .low_clock_rate_mode,
		.test_pattern_enable, .cal_start, .dout_i, .dout_q, .dout_id,
		.dout_qd, .dout_or);
	aecr_host host (.clk, .frame_active, .bit_valid, .bit_data);
	function automatic logic [7:0] nxt(input logic [7:0] v);
		nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nxt
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		#1;
		lfsr = nxt(lfsr);
		{adc_i, adc_q, adc_id, adc_qd} = {lfsr, ~lfsr, nxt(lfsr), lfsr ^ 8'h5A};
		adc_or = lfsr[0];
		cyc++;
		if (cyc == 6000) begin
			failures++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task automatic report(input string n, input logic [48:0] e, g);
		num_checks++;
		if (e !== g) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : report
	task automatic check_fields;
		logic [48:0] e;
		e = extended_mode ? {rg[3][15:7], rg[11][15:7], rg[10][15:7],
			rg[14][15:8], rg[15][15:7], rg[9][15:12], rg[9][10]}
			: {9'h100, 9'h100, 31'h0};
		repeat (5) @(posedge clk);
		#2;
		report("controls", e, ctl);
	endtask : check_fields
	task automatic check_dout(input logic [32:0] e);
		report("dout", {16'h0, e}, {16'h0, dv});
	endtask : check_dout
	task automatic do_reset;
		nrst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'b1;
		foreach (rg[i]) rg[i] = 16'h0;
		{rg[3], rg[11]} = {2{aecr_pkg::RST_GAIN}};
		rg[9] = aecr_pkg::RST_EXT_CFG;
	endtask : do_reset
	task automatic wr(input logic [3:0] a, input logic [15:0] v, input int g);
		host.send(a, v, g, 20);
		if (a inside {4'h3, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF})
			rg[a] = v;
	endtask : wr
	initial begin
		{adc_i, adc_q, adc_id, adc_qd, adc_or} = 33'h0;
		{failures, num_checks, cyc} = 0;
		lfsr = 8'h1A;
		extended_mode = 1'b1;
		do_reset;
		check_fields;
		for (int a = 0; a < 16; a++) begin
			d = {lfsr, nxt(lfsr)};
			if (a == 3 || a == 11)
				d[15:7] = 9'h0C0 + {1'b0, lfsr};
			if (a == 9)
				d[15] = 1'b0;
			wr(a[3:0], d, a % 2);
		end
		host.end_frame;
		check_fields;
		wr(4'hA, 16'h0080, 0);
		host.end_frame;
		check_fields;
		host.send(4'hB, 16'h0000, 0, 12);
		host.end_frame;
		check_fields;
		extended_mode = 1'b0;
		check_fields;
		extended_mode = 1'b1;
		wr(4'h9, 16'h8000, 0);
		host.end_frame;
		check_fields;
		ph = dout_or;
		for (int i = 0; i < 6; i++) begin
			check_dout(ph ? 33'h1FBFCFDFE : 33'h004030201);
			ph = ~ph;
			@(posedge clk);
			#2;
		end
		wr(4'h9, 16'h0000, 0);
		host.end_frame;
		check_fields;
		@(negedge clk);
		pv = {adc_or, adc_i, adc_q, adc_id, adc_qd};
		@(posedge clk);
		#2;
		check_dout(pv);
		do_reset;
		check_fields;
		complete_run;
	end
endmodule : aecr_regs_tb
bind aecr_regs aecr_chk chk (.clk, .nrst, .frame_active, .extended_mode,
	.adc_i, .i_gain_code, .q_gain_code, .q_offset_mag, .q_offset_neg,
	.phase_fine, .sample_clock_invert, .phase_coarse, .phase_mid,
	.test_pattern_enable, .cal_start, .dout_i, .dout_q, .dout_id,
	.dout_qd, .dout_or);
`default_nettype wire
